//--- logic/bsp_sram_end.sv
/*
 SRAM end of the burst port link: clock edge detection, DLL lock model,
 port arbitration, masked write bursts and latency-timed read bursts.
 Assumes the link signals come from logic on mclk, so no synchronisers;
 in dual clock mode the output clock pair is in phase with the input pair.
*/
`default_nettype none

module bsp_sram_end
   import bsp_pkg::*;
#(
   parameter int AW       = 8,
   parameter int LANES    = 2,
   parameter int LOCK_CYC = BSP_LOCK_CYC
) (
   input  wire logic mclk,
   input  wire logic nrst,
   bsp_link_if.sram  link,
   output logic      dllLocked,
   output logic      singleClk
);
   localparam int DW    = LANES * BSP_LANE_W;
   localparam int DEPTH = 1 << AW;
   localparam int LW    = $clog2(LOCK_CYC + 1);
   localparam int SW    = $clog2(BSP_STOP_CYC + 1);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic                   kPrev_ff;
   logic                   kNPrev_ff;
   logic                   cPrev_ff;
   logic                   cNPrev_ff;
   logic                   strapDone_ff;
   logic                   singleClk_ff;
   logic [SW-1:0]          stopCnt_ff;
   bsp_dll_t               dllState_ff;
   bsp_dll_t               nxt_dllState;
   logic [LW-1:0]          lockCnt_ff;
   logic [LW-1:0]          nxt_lockCnt;
   logic                   dllLocked_ff;
   logic                   rdPrev_ff;
   logic                   wrPrev_ff;
   logic [BSP_WR_SH_W-1:0] wrSh_ff;
   logic [BSP_RD_SH_W-1:0] rdSh_ff;
   logic [AW-1:0]          wrAddrQ_ff;
   logic [AW-1:0]          wrAddrA_ff;
   logic [AW-1:0]          rdAddrQ_ff;
   logic [AW-1:0]          rdAddrA_ff;
   logic [DW-1:0]          rdData_ff;
   logic                   rdOe_ff;
   logic [DW-1:0]          mem_ff [DEPTH];

   wire                    kRise;
   wire                    kNRise;
   wire                    kEdge;
   wire                    cEdge;
   wire                    tEdge;
   wire                    clkStopped;
   wire                    dllOn;
   wire                    rdGo;
   wire                    wrGo;
   wire [BSP_BURST-1:0]    wrSel;
   wire [1:0]              wrBeat;
   wire [AW-1:0]           wrWord;
   wire                    wrAct;
   wire [DW-1:0]           wrOld;
   wire [DW-1:0]           wrMerged;
   wire [BSP_BURST-1:0]    rdSel;
   wire [1:0]              rdBeat;
   wire [AW-1:0]           rdWord;
   wire                    rdLaunch;

   // -----------------------------------------------------------------
   // Clock phase edges
   // -----------------------------------------------------------------
   assign kRise  = link.kClk & ~kPrev_ff;
   assign kNRise = link.kClkN & ~kNPrev_ff;
   assign kEdge  = kRise | kNRise;
   assign cEdge  = (link.cClk & ~cPrev_ff) | (link.cClkN & ~cNPrev_ff);
   assign tEdge  = singleClk_ff ? kEdge : cEdge;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         kPrev_ff  <= BSP_CLK_PARK;
         kNPrev_ff <= BSP_CLK_PARK;
         cPrev_ff  <= BSP_CLK_PARK;
         cNPrev_ff <= BSP_CLK_PARK;
      end else begin
         kPrev_ff  <= link.kClk;
         kNPrev_ff <= link.kClkN;
         cPrev_ff  <= link.cClk;
         cNPrev_ff <= link.cClkN;
      end
   end

   // -----------------------------------------------------------------
   // Clock mode strap
   // -----------------------------------------------------------------
   // Caught at the first K edge: parked clocks are all high and prove nothing
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         strapDone_ff <= 1'b0;
         singleClk_ff <= 1'b0;
      end else if (!strapDone_ff && kEdge) begin
         strapDone_ff <= 1'b1;
         singleClk_ff <= link.cClk & link.cClkN;
      end
   end

   // -----------------------------------------------------------------
   // DLL lock model
   // -----------------------------------------------------------------
   assign dllOn      = link.loopDisableN;
   assign clkStopped = (stopCnt_ff == SW'(BSP_STOP_CYC));

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         stopCnt_ff <= '0;
      end else if (kEdge) begin
         stopCnt_ff <= '0;
      end else if (!clkStopped) begin
         stopCnt_ff <= stopCnt_ff + SW'(1);
      end
   end

   always_comb begin
      nxt_dllState = dllState_ff;
      nxt_lockCnt  = lockCnt_ff;
      case (dllState_ff)
         BSP_DLL_RESET: begin
            if (kRise) begin
               nxt_dllState = BSP_DLL_COUNT;
               nxt_lockCnt  = LW'(1);
            end
         end
         BSP_DLL_COUNT: begin
            if (kRise) begin
               nxt_lockCnt = lockCnt_ff + LW'(1);
               if (lockCnt_ff == LW'(LOCK_CYC - 1)) begin
                  nxt_dllState = BSP_DLL_LOCKED;
               end
            end
         end
         BSP_DLL_LOCKED: begin
            nxt_lockCnt = lockCnt_ff;
         end
         default: begin
            nxt_dllState = BSP_DLL_RESET;
         end
      endcase
      // A clock with no edge for BSP_STOP_CYC mclk cycles, or the loop switched off, restarts the count
      if (!dllOn || clkStopped) begin
         nxt_dllState = BSP_DLL_RESET;
         nxt_lockCnt  = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         dllState_ff  <= BSP_DLL_RESET;
         lockCnt_ff   <= '0;
         dllLocked_ff <= 1'b0;
      end else begin
         dllState_ff  <= nxt_dllState;
         lockCnt_ff   <= nxt_lockCnt;
         dllLocked_ff <= (nxt_dllState == BSP_DLL_LOCKED);
      end
   end

   // -----------------------------------------------------------------
   // Port arbitration
   // -----------------------------------------------------------------
   // Read wins a tie; a port that started on the last rise is ignored
   assign rdGo = kRise & ~link.readPortSelectN & ~rdPrev_ff;
   assign wrGo = kRise & ~link.writePortSelectN & ~wrPrev_ff & ~rdGo;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdPrev_ff <= 1'b0;
         wrPrev_ff <= 1'b0;
      end else if (kRise) begin
         rdPrev_ff <= rdGo;
         wrPrev_ff <= wrGo;
      end
   end

   // -----------------------------------------------------------------
   // Write bursts
   // -----------------------------------------------------------------
   assign wrSel  = wrSh_ff[BSP_WR_SH_W-1 -: BSP_BURST] & {BSP_BURST{kEdge}};
   assign wrBeat = wrSel[3] ? 2'h3 : wrSel[2] ? 2'h2 : wrSel[1] ? 2'h1 : 2'h0;
   assign wrWord = (wrSel[0] ? wrAddrQ_ff : wrAddrA_ff) + AW'(wrBeat);
   assign wrOld  = mem_ff[wrWord];
   assign wrAct  = (|wrSel) & ~(&link.byteLaneMaskN);

   // Each beat carries its own lane mask; masked lanes keep the old word
   genvar lane;
   generate
      for (lane = 0; lane < LANES; lane++) begin : g_lane
         assign wrMerged[lane*BSP_LANE_W +: BSP_LANE_W] =
            link.byteLaneMaskN[lane] ? wrOld[lane*BSP_LANE_W +: BSP_LANE_W]
                                     : link.wrData[lane*BSP_LANE_W +: BSP_LANE_W];
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wrSh_ff    <= '0;
         wrAddrQ_ff <= '0;
         wrAddrA_ff <= '0;
      end else begin
         if (kEdge) begin
            wrSh_ff <= {wrSh_ff[BSP_WR_SH_W-2:0], wrGo};
         end
         if (wrGo) begin
            wrAddrQ_ff <= link.addr;
         end
         if (wrSel[0]) begin
            wrAddrA_ff <= wrAddrQ_ff;
         end
      end
   end

   // Storage holds no reset; only control state needs a defined value
   always_ff @(posedge mclk) begin
      if (wrAct) begin
         mem_ff[wrWord] <= wrMerged;
      end
   end

   // -----------------------------------------------------------------
   // Read bursts
   // -----------------------------------------------------------------
   assign rdSel    = dllOn ? rdSh_ff[BSP_LAT_DLL_ON+2 -: BSP_BURST]
                           : rdSh_ff[BSP_LAT_DLL_OFF+2 -: BSP_BURST];
   assign rdBeat   = rdSel[3] ? 2'h3 : rdSel[2] ? 2'h2 : rdSel[1] ? 2'h1 : 2'h0;
   assign rdWord   = (rdSel[0] ? rdAddrQ_ff : rdAddrA_ff) + AW'(rdBeat);
   assign rdLaunch = tEdge & (|rdSel);

   // Write beats reach the array two edges after their start, before any
   // read beat that a later start can launch, so the newest word is read
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdSh_ff    <= '0;
         rdAddrQ_ff <= '0;
         rdAddrA_ff <= '0;
         rdData_ff  <= '0;
         rdOe_ff    <= 1'b0;
      end else begin
         if (tEdge) begin
            rdSh_ff <= {rdSh_ff[BSP_RD_SH_W-2:0], rdGo};
            rdOe_ff <= |rdSel;
         end
         if (rdGo) begin
            rdAddrQ_ff <= link.addr;
         end
         if (tEdge & rdSel[0]) begin
            rdAddrA_ff <= rdAddrQ_ff;
         end
         if (rdLaunch) begin
            rdData_ff <= mem_ff[rdWord];
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // With no clock edges only the stop counter and DLL model move; the rest of a stopped link holds state
   assign link.rdData   = rdData_ff;
   assign link.rdDataOe = rdOe_ff;
   assign dllLocked     = dllLocked_ff;
   assign singleClk     = singleClk_ff;
endmodule : bsp_sram_end

`default_nettype wire

//--- logic/bsp_pkg.sv
/*
 Shared constants and types for the burst SRAM port link.
 Assumes both ends run on one 125 MHz clock (mclk) and that the controller
 end makes the input and output clock pairs by dividing mclk by two.
*/
// Operation
// - Controller keeps DLL clock at or above 120 MHz
// - DLL locks after 1024 stable clock rises
// - Clocks stopped 30 ns reset the DLL
// - Loop disable low: one cycle read latency
// - Write at rise t, beats t+1, t+2
// - Read beats from negative rise of t+1
// - Burst walks four consecutive word addresses
// - Same-type start on consecutive rises is dropped
// - Write captured, read launched on both phases
// - Deselected after reset, read outputs released
// - Stopped clocks park high, state held
// - Four lane masks gate x36 write beats
// - All masks high leaves memory unchanged
// - Mask applied separately on every beat
// - Output clocks high at power-on: single clock
// - Both selects from idle alternate, read first
`default_nettype none

package bsp_pkg;
   // -----------------------------------------------------------------
   // Data layout
   // -----------------------------------------------------------------
   localparam int BSP_LANE_W    = 9;
   localparam int BSP_BURST     = 4;
   // -----------------------------------------------------------------
   // Clocking and timing
   // -----------------------------------------------------------------
   localparam int BSP_MCLK_MHZ    = 125;
   localparam int BSP_MCLK_NS     = 8;
   localparam int BSP_KCLK_MHZ    = BSP_MCLK_MHZ / 2;
   localparam int BSP_DLL_MIN_MHZ = 120;
   localparam int BSP_STOP_NS     = 30;
   // Least time, so rounded up to whole mclk cycles
   localparam int BSP_STOP_CYC    = (BSP_STOP_NS + BSP_MCLK_NS - 1) / BSP_MCLK_NS;
   localparam int BSP_LOCK_CYC    = 1024;
   // Latencies in clock-phase edges from the starting rise
   localparam int BSP_LAT_DLL_ON  = 3;
   localparam int BSP_LAT_DLL_OFF = 2;
   localparam int BSP_WR_LAT      = 2;
   localparam int BSP_WR_SH_W     = BSP_WR_LAT + BSP_BURST - 1;
   localparam int BSP_RD_SH_W     = BSP_LAT_DLL_ON + BSP_BURST - 1;
   localparam int BSP_WR_LOADS    = BSP_WR_LAT + BSP_BURST - 1;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic BSP_CLK_PARK   = 1'b1;
   localparam logic BSP_SEL_IDLE_N = 1'b1;

   typedef enum logic [1:0] {
      BSP_DLL_RESET,
      BSP_DLL_COUNT,
      BSP_DLL_LOCKED
   } bsp_dll_t;
endpackage : bsp_pkg

`default_nettype wire

//--- logic/bsp_link_if.sv
/*
 Link between the controller end and the SRAM end.
 Assumes both ends share mclk; every link signal changes once per mclk.
 Read data is an output with an enable; the controller end samples it only while the enable is high.
*/
`default_nettype none

interface bsp_link_if
   import bsp_pkg::*;
#(
   parameter int AW    = 8,
   parameter int LANES = 2
) ();
   localparam int DW = LANES * BSP_LANE_W;

   logic             kClk;
   logic             kClkN;
   logic             cClk;
   logic             cClkN;
   logic             loopDisableN;
   logic             readPortSelectN;
   logic             writePortSelectN;
   logic [AW-1:0]    addr;
   logic [LANES-1:0] byteLaneMaskN;
   logic [DW-1:0]    wrData;
   logic [DW-1:0]    rdData;
   logic             rdDataOe;

   modport sram (
      input  kClk, kClkN, cClk, cClkN, loopDisableN,
      input  readPortSelectN, writePortSelectN, addr, byteLaneMaskN, wrData,
      output rdData, rdDataOe
   );

   modport ctrl (
      output kClk, kClkN, cClk, cClkN, loopDisableN,
      output readPortSelectN, writePortSelectN, addr, byteLaneMaskN, wrData,
      input  rdData, rdDataOe
   );
endinterface : bsp_link_if

`default_nettype wire

//--- logic/bsp_ctrl_end.sv
/*
 Controller end of the burst port link: clock pair generation with
 parking, DLL enable and lock wait, command issue and burst assembly.
 Assumes a user on mclk; one command every other input clock rise, or every fourth after a write.
*/
`default_nettype none

module bsp_ctrl_end
   import bsp_pkg::*;
#(
   parameter int AW         = 8,
   parameter int LANES      = 2,
   parameter bit SINGLE_CLK = 1'b0,
   parameter bit USE_DLL    = 1'b1,
   parameter int LOCK_CYC   = BSP_LOCK_CYC
) (
   input  wire logic                              mclk,
   input  wire logic                              nrst,
   input  wire logic                              clkRun,
   input  wire logic                              cmdValid,
   input  wire logic                              cmdWrite,
   input  wire logic [AW-1:0]                     cmdAddr,
   input  wire logic [BSP_BURST*LANES*BSP_LANE_W-1:0] cmdWrData,
   input  wire logic [BSP_BURST*LANES-1:0]        cmdMaskN,
   output logic                                   cmdReady,
   output logic [BSP_BURST*LANES*BSP_LANE_W-1:0]  rdWords,
   output logic                                   rdValid,
   bsp_link_if.ctrl                               link
);
   localparam int DW = LANES * BSP_LANE_W;
   localparam int LW = $clog2(LOCK_CYC + 1);
   // The divided clock is too slow for the loop, so it is kept off then
   localparam bit DLL_OK = USE_DLL && (BSP_KCLK_MHZ >= BSP_DLL_MIN_MHZ);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic                         run_ff, kClk_ff, kClkN_ff, cClk_ff, cClkN_ff;
   logic                         rdSelN_ff, wrSelN_ff, cmdReady_ff, rdValid_ff;
   logic [AW-1:0]                addr_ff;
   logic [LANES-1:0]             mask_ff;
   logic [DW-1:0]                wrData_ff;
   logic [BSP_BURST*DW-1:0]      wrBuf_ff;
   logic [BSP_BURST*LANES-1:0]   maskBuf_ff;
   logic [2:0]                   wrCnt_ff;
   logic [1:0]                   rdOut_ff;
   logic [1:0]                   rdCnt_ff;
   logic [LW-1:0]                lockCnt_ff;
   logic [(BSP_BURST-1)*DW-1:0]  rdBuf_ff;
   logic [BSP_BURST*DW-1:0]      rdWords_ff;

   wire riseNow = kClk_ff & ~kClkN_ff;
   wire busy    = (wrCnt_ff != 3'h0) | (rdOut_ff != 2'h0);
   wire stopNow = ~clkRun & ~busy & riseNow;
   wire toggle  = run_ff & ~stopNow;
   wire nxtK    = toggle ? ~kClk_ff : BSP_CLK_PARK;
   wire nxtKN   = toggle ? kClk_ff : BSP_CLK_PARK;
   wire lockOk  = ~DLL_OK | (lockCnt_ff == LW'(LOCK_CYC));
   wire accept  = cmdValid & cmdReady_ff;
   wire wrLoad  = (wrCnt_ff != 3'h0) & (wrCnt_ff <= 3'(BSP_BURST));
   wire lastRd  = link.rdDataOe & (rdCnt_ff == 2'h3);

   // -----------------------------------------------------------------
   // Clock pairs and DLL wait
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         run_ff     <= 1'b0;
         kClk_ff    <= BSP_CLK_PARK;
         kClkN_ff   <= BSP_CLK_PARK;
         cClk_ff    <= BSP_CLK_PARK;
         cClkN_ff   <= BSP_CLK_PARK;
         lockCnt_ff <= '0;
      end else begin
         run_ff   <= run_ff ? ~stopNow : clkRun;
         kClk_ff  <= nxtK;
         kClkN_ff <= nxtKN;
         cClk_ff  <= SINGLE_CLK | nxtK;
         cClkN_ff <= SINGLE_CLK | nxtKN;
         // Each restart is waited out in full; a short stop may not need it
         if (!run_ff) begin
            lockCnt_ff <= '0;
         end else if (riseNow && lockCnt_ff != LW'(LOCK_CYC)) begin
            lockCnt_ff <= lockCnt_ff + LW'(1);
         end
      end
   end

   // -----------------------------------------------------------------
   // Command issue
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cmdReady_ff <= 1'b0;
         rdSelN_ff   <= BSP_SEL_IDLE_N;
         wrSelN_ff   <= BSP_SEL_IDLE_N;
         addr_ff     <= '0;
         wrCnt_ff    <= 3'h0;
         rdOut_ff    <= 2'h0;
      end else begin
         // Only after an idle rise, so no port starts on two rises in a row
         cmdReady_ff <= run_ff & clkRun & riseNow & rdSelN_ff & wrSelN_ff
                        & (wrCnt_ff == 3'h0) & lockOk;
         rdSelN_ff   <= ~(accept & ~cmdWrite);
         wrSelN_ff   <= ~(accept & cmdWrite);
         if (accept) begin
            addr_ff <= cmdAddr;
         end
         if (accept & cmdWrite) begin
            wrCnt_ff <= 3'(BSP_WR_LOADS);
         end else if (wrCnt_ff != 3'h0) begin
            wrCnt_ff <= wrCnt_ff - 3'h1;
         end
         rdOut_ff <= rdOut_ff + 2'(accept & ~cmdWrite) - 2'(lastRd);
      end
   end

   // -----------------------------------------------------------------
   // Write beats
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wrBuf_ff   <= '0;
         maskBuf_ff <= '1;
         wrData_ff  <= '0;
         mask_ff    <= '1;
      end else if (accept & cmdWrite) begin
         wrBuf_ff   <= cmdWrData;
         maskBuf_ff <= cmdMaskN;
      end else if (wrLoad) begin
         wrData_ff  <= wrBuf_ff[DW-1:0];
         mask_ff    <= maskBuf_ff[LANES-1:0];
         wrBuf_ff   <= wrBuf_ff >> DW;
         maskBuf_ff <= maskBuf_ff >> LANES;
      end else begin
         mask_ff    <= '1;
      end
   end

   // -----------------------------------------------------------------
   // Read assembly
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdCnt_ff   <= 2'h0;
         rdBuf_ff   <= '0;
         rdWords_ff <= '0;
         rdValid_ff <= 1'b0;
      end else begin
         rdValid_ff <= lastRd;
         if (link.rdDataOe) begin
            rdCnt_ff <= rdCnt_ff + 2'h1;
            rdBuf_ff <= {link.rdData, rdBuf_ff[(BSP_BURST-1)*DW-1:DW]};
         end
         if (lastRd) begin
            rdWords_ff <= {link.rdData, rdBuf_ff};
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign link.kClk             = kClk_ff;
   assign link.kClkN            = kClkN_ff;
   assign link.cClk             = cClk_ff;
   assign link.cClkN            = cClkN_ff;
   assign link.loopDisableN     = DLL_OK;
   assign link.readPortSelectN  = rdSelN_ff;
   assign link.writePortSelectN = wrSelN_ff;
   assign link.addr             = addr_ff;
   assign link.byteLaneMaskN    = mask_ff;
   assign link.wrData           = wrData_ff;
   assign cmdReady              = cmdReady_ff;
   assign rdWords               = rdWords_ff;
   assign rdValid               = rdValid_ff;
endmodule : bsp_ctrl_end

`default_nettype wire

//--- bench/bsp_link_properties.sv
/* Protocol properties on the wires of the link between the two ends.
   Assumes tb_top hands it the link signals; one clock, mclk. */
`default_nettype none
module bsp_link_properties (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic kClk,
   input wire logic kClkN,
   input wire logic loopDisableN,
   input wire logic readPortSelectN,
   input wire logic writePortSelectN,
   input wire logic rdDataOe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // Start detect
   // ----------------
   logic kPrev_ff;
   always_ff @(posedge mclk) begin
      kPrev_ff <= kClk;
   end
   wire logic rdGo = kClk & ~kPrev_ff & ~readPortSelectN;
   wire logic wrGo = kClk & ~kPrev_ff & ~writePortSelectN;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   property p_idle; $rose(nrst) |-> !rdDataOe && readPortSelectN && writePortSelectN; endproperty
   a_idle: assert property (p_idle) else $error("port busy after reset");
   property p_rdOne; rdGo |-> ##2 !rdGo; endproperty
   a_rdOne: assert property (p_rdOne) else $error("read on next rise");
   property p_wrOne; wrGo |-> ##2 !wrGo; endproperty
   a_wrOne: assert property (p_wrOne) else $error("write on next rise");
   property p_rdLat; rdGo |-> ##3 rdDataOe [*4]; endproperty
   a_rdLat: assert property (p_rdLat) else $error("read beats late");
   property p_oeCause; $rose(rdDataOe) |-> $past(rdGo, 3); endproperty
   a_oeCause: assert property (p_oeCause) else $error("beat without read");
   property p_oeEnd; $fell(rdDataOe) |-> $past(rdGo, 7); endproperty
   a_oeEnd: assert property (p_oeEnd) else $error("release misplaced");
   property p_dllOff; !loopDisableN; endproperty
   a_dllOff: assert property (p_dllOff) else $error("loop on below 120 MHz");
   property p_kNeg; $rose(kClk) |=> $rose(kClkN); endproperty
   a_kNeg: assert property (p_kNeg) else $error("no negative rise");
   c_rd: cover property (rdGo);
   c_wr: cover property (wrGo);
   c_park: cover property ((kClk && kClkN) [*3]);
endmodule : bsp_link_properties
`default_nettype wire

//--- bench/tb_top.sv
/* Bench: controller end and SRAM end joined by the link.
   Assumes one mclk; expected words come from a bench memory. */
`default_nettype none
`define CHK(n, e, s) begin checksDone++; if ((s) !== (e)) begin nMismatch++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
   import bsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        clkRun = 1'b0;
   logic        cmdValid = 1'b0;
   logic        cmdWrite = 1'b0;
   logic [7:0]  cmdAddr = 8'h00;
   logic [71:0] cmdWrData = 72'h0;
   logic [7:0]  cmdMaskN = 8'hFF;
   logic        cmdReady, rdValid, dllLocked, singleClk;
   logic [71:0] rdWords;
   logic [17:0] mem [256];
   int          nMismatch = 0;
   int          checksDone = 0;
   int          cyc = 0;
   bsp_link_if #(.AW(8), .LANES(2)) link ();
   bsp_ctrl_end #(.LOCK_CYC(8)) i_bsp_ctrl_end (.mclk, .nrst, .clkRun, .cmdValid,
      .cmdWrite, .cmdAddr, .cmdWrData, .cmdMaskN, .cmdReady, .rdWords, .rdValid, .link);
   bsp_sram_end #(.LOCK_CYC(8)) i_bsp_sram_end (.mclk, .nrst, .link, .dllLocked, .singleClk);
   bsp_link_properties i_bsp_link_properties (.mclk, .nrst, .kClk(link.kClk),
      .kClkN(link.kClkN), .loopDisableN(link.loopDisableN), .rdDataOe(link.rdDataOe),
      .readPortSelectN(link.readPortSelectN), .writePortSelectN(link.writePortSelectN));
   always #4 mclk = ~mclk;
   // Whole run needs under a hundred cycles; ceiling leaves ample margin
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         nMismatch++;
         testDone();
      end
   end
   task automatic testDone();
      if (nMismatch == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : testDone
   // One command; writes update the bench memory, reads are judged
   task automatic xfer(input logic w, input logic [7:0] a, input logic [71:0] d,
                       input logic [7:0] m);
      logic [71:0] exp;
      int n;
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdWrite <= w;
      cmdAddr <= a;
      cmdWrData <= d;
      cmdMaskN <= m;
      n = 0;
      do begin @(posedge mclk); n++; end while (cmdReady !== 1'b1 && n < 50);
      cmdValid <= 1'b0;
      `CHK("cmdReady", 1'b1, cmdReady)
      for (int i = 0; i < 4; i++) begin
         for (int l = 0; l < 2; l++) begin
            if (w && !m[2*i+l]) mem[8'(a+i)][9*l+:9] = d[18*i+9*l+:9];
            exp[18*i+9*l+:9] = mem[8'(a+i)][9*l+:9];
         end
      end
      if (!w) begin
         n = 0;
         do begin @(posedge mclk); n++; end while (rdValid !== 1'b1 && n < 50);
         `CHK("rdValid", 1'b1, rdValid)
         `CHK("rdWords", exp, rdWords)
      end
   endtask : xfer
   // Top address wraps; read issued right behind the write
   task automatic tBasic();
      xfer(1'b1, 8'hFE, 72'h123456789ABCDEF012, 8'h00);
      xfer(1'b0, 8'hFE, 72'h0, 8'hFF);
      `CHK("singleClk", 1'b0, singleClk)
      `CHK("dllLocked", 1'b0, dllLocked)
   endtask : tBasic
   // Beat masks: upper only, lower only, none, both
   task automatic tMask();
      xfer(1'b1, 8'hFE, 72'hFEDCBA9876543210AB, 8'h39);
      xfer(1'b0, 8'hFE, 72'h0, 8'hFF);
   endtask : tMask
   task automatic tStop();
      clkRun <= 1'b0;
      repeat (10) @(posedge mclk);
      `CHK("parked", 4'hF, {link.kClk, link.kClkN, link.cClk, link.cClkN})
      clkRun <= 1'b1;
      xfer(1'b0, 8'hFE, 72'h0, 8'hFF);
   endtask : tStop
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      clkRun <= 1'b1;
      tBasic();
      tMask();
      tStop();
      testDone();
   end
endmodule : tb_top
`default_nettype wire
